// [common/viu_defines.vh]
`ifndef VIU_DEFINES_VH
`define VIU_DEFINES_VH

// Register byte addresses on the AXI4-Lite slave.
`define VIU_ADDR_IE 6'h00
`define VIU_ADDR_VEC 6'h04
`define VIU_ADDR_BUSEV_EN 6'h08
`define VIU_ADDR_STS 6'h0C
`define VIU_ADDR_CLR 6'h10
`define VIU_ADDR_IRQ_EN 6'h14

// Standard enable register fields.
`define VIU_IE_AGG 0
`define VIU_IE_T0 1
`define VIU_IE_PORT 2
`define VIU_IE_T1 3
`define VIU_IE_SER 4
`define VIU_IE_T2 5
`define VIU_IE_RSV 6
`define VIU_IE_GATE 7
`define VIU_IE_RESET 8'h00
`define VIU_IE_WMASK 8'hBF

// Bus-state event enable fields.
`define VIU_BE_POWER_ON_EVENT 3
`define VIU_BE_POWER_OFF_EVENT 4
`define VIU_BE_RESUME 5
`define VIU_BE_SUSPEND 6
`define VIU_BE_BUSRST 7
`define VIU_BE_RESET 8'h00
`define VIU_BE_WMASK 8'hF8

// Vector register fields.
`define VIU_VEC_IDX_LSB 1
`define VIU_VEC_GRP_LSB 4
`define VIU_VEC_RESET 8'h00

// Fixed branch locations of the standard sources.
`define VIU_LOC_RESET 16'h0000
`define VIU_LOC_AGG 16'h0003
`define VIU_LOC_T0 16'h000B
`define VIU_LOC_PORT 16'h0013
`define VIU_LOC_T1 16'h001B
`define VIU_LOC_SER 16'h0023
`define VIU_LOC_T2 16'h002B

// Block interrupt status bits.
`define VIU_STS_QUEUED 0
`define VIU_STS_EMPTY_RETIRE 1
`define VIU_STS_WIDTH 2

`define VIU_RESP_OKAY 2'h0
`define VIU_RESP_SLVERR 2'h2

`endif

// [rtl/viu_top.v]
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "viu_defines.vh"

module viu_top (
  input wire mclk,
  input wire rst_n,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire timer0_req,
  input wire port_irq_req,
  input wire timer1_req,
  input wire serial_port_req,
  input wire timer2_req,
  input wire [2:0] out_ep_event,
  input wire [2:0] in_ep_event,
  input wire setup_overwrite_event,
  input wire setup_received_event,
  input wire power_on_event,
  input wire power_off_event,
  input wire resume_event,
  input wire suspend_event,
  input wire bus_reset_event,
  input wire serial_bus_transmit_empty,
  input wire serial_bus_receive_full,
  input wire in_ep0_event,
  input wire out_ep0_event,
  output reg internal_aggregate_irq_n,
  output reg [5:0] core_irq_q,
  output reg [15:0] core_branch_addr_q,
  output reg irq
);

  localparam NGRP = 4;

  reg [7:0] interrupt_enable_ctrl_q;
  reg [7:0] interrupt_vector_id_q;
  reg [7:0] busev_en_q;
  reg [`VIU_STS_WIDTH-1:0] sts_q;
  reg [`VIU_STS_WIDTH-1:0] irq_en_q;
  reg aw_have_q;
  reg w_have_q;
  reg [5:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
  wire wr_ie = wr_fire && awaddr_q == `VIU_ADDR_IE;
  wire wr_vec = wr_fire && awaddr_q == `VIU_ADDR_VEC;
  wire wr_be = wr_fire && awaddr_q == `VIU_ADDR_BUSEV_EN;
  wire wr_clr = wr_fire && awaddr_q == `VIU_ADDR_CLR;
  wire wr_irqen = wr_fire && awaddr_q == `VIU_ADDR_IRQ_EN;
  wire wr_hit = wr_ie | wr_vec | wr_be | wr_clr | wr_irqen;

  // Per-group raw requests, one byte per group 1..4; only the listed
  // index positions are wired, so reserved codes can never be queued.
  wire [NGRP*8-1:0] raw_all;
  assign raw_all[7:0] = {4'h0, out_ep_event, 1'b0};
  assign raw_all[15:8] = {4'h0, in_ep_event, 1'b0};
  assign raw_all[23:16] = {1'b0,
    bus_reset_event & busev_en_q[`VIU_BE_BUSRST],
    suspend_event & busev_en_q[`VIU_BE_SUSPEND],
    resume_event & busev_en_q[`VIU_BE_RESUME],
    power_off_event & busev_en_q[`VIU_BE_POWER_OFF_EVENT],
    power_on_event & busev_en_q[`VIU_BE_POWER_ON_EVENT],
    setup_received_event, setup_overwrite_event};
  assign raw_all[31:24] = {4'h0, out_ep0_event, in_ep0_event,
    serial_bus_receive_full, serial_bus_transmit_empty};

  wire [NGRP*3-1:0] head_all;
  wire [NGRP-1:0] nonempty;
  wire [NGRP-1:0] pushed;
  wire vec_busy = interrupt_vector_id_q != `VIU_VEC_RESET;

  function [2:0] lowest_idx;
    input [7:0] v;
    integer k;
    begin
      lowest_idx = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest_idx = k[2:0];
        end
      end
    end
  endfunction

  // Each group keeps an arrival-ordered queue of indices. One new source
  // enters per cycle; simultaneous arrivals enter lowest index first.
  genvar gi;
  generate
    for (gi = 0; gi < NGRP; gi = gi + 1) begin : grp
      reg [7:0] pend_q;
      reg [7:0] inq_q;
      reg [23:0] fifo_q;
      reg [3:0] cnt_q;
      reg [7:0] pend_d;
      reg [7:0] inq_d;
      reg [23:0] fifo_d;
      reg [3:0] cnt_d;
      wire [7:0] raw = raw_all[gi*8 +: 8];
      wire [7:0] cand = pend_q & ~inq_q;
      wire push = |cand;
      wire [2:0] pidx = lowest_idx(cand);
      wire [2:0] head = fifo_q[2:0];
      wire pop = wr_vec && vec_busy &&
        interrupt_vector_id_q[7:4] == gi + 1;
      wire [7:0] hmask = pop ? (8'h01 << head) : 8'h00;
      assign head_all[gi*3 +: 3] = head;
      assign nonempty[gi] = cnt_q != 4'h0;
      assign pushed[gi] = push;

      always @* begin
        // A new event on the retiring source keeps it pending.
        pend_d = (pend_q & ~hmask) | raw;
        inq_d = inq_q & ~hmask;
        fifo_d = fifo_q;
        cnt_d = cnt_q;
        if (pop) begin
          fifo_d = {3'h0, fifo_q[23:3]};
          cnt_d = cnt_q - 4'h1;
        end
        if (push) begin
          fifo_d[cnt_d*3 +: 3] = pidx;
          cnt_d = cnt_d + 4'h1;
          inq_d = inq_d | (8'h01 << pidx);
        end
      end

      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          pend_q <= 8'h00;
          inq_q <= 8'h00;
          fifo_q <= 24'h000000;
          cnt_q <= 4'h0;
        end else begin
          pend_q <= pend_d;
          inq_q <= inq_d;
          fifo_q <= fifo_d;
          cnt_q <= cnt_d;
        end
      end
    end
  endgenerate

  // Highest group wins; the vector register is refreshed every cycle.
  reg [7:0] vec_d;
  integer gsel;
  always @* begin
    vec_d = `VIU_VEC_RESET;
    for (gsel = 0; gsel < NGRP; gsel = gsel + 1) begin
      if (nonempty[gsel]) begin
        vec_d = {gsel[3:0] + 4'h1, head_all[gsel*3 +: 3], 1'b0};
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_vector_id_q <= `VIU_VEC_RESET;
    end else begin
      // Bit 0 is hard zero; the group and index fields span 32 vectors.
      interrupt_vector_id_q <= {vec_d[7:1], 1'b0};
    end
  end

  // Standard sources. The aggregate stands in for interrupt-0; the
  // external pins have no path here at all.
  wire agg_pending = |nonempty;
  wire [5:0] std_src = {timer2_req, serial_port_req, timer1_req,
    port_irq_req, timer0_req, agg_pending};
  wire [5:0] std_gated = std_src & interrupt_enable_ctrl_q[5:0] &
    {6{interrupt_enable_ctrl_q[`VIU_IE_GATE]}};

  reg [15:0] branch_d;
  always @* begin
    branch_d = `VIU_LOC_RESET;
    if (std_gated[`VIU_IE_T2]) begin
      branch_d = `VIU_LOC_T2;
    end
    if (std_gated[`VIU_IE_SER]) begin
      branch_d = `VIU_LOC_SER;
    end
    if (std_gated[`VIU_IE_T1]) begin
      branch_d = `VIU_LOC_T1;
    end
    if (std_gated[`VIU_IE_PORT]) begin
      branch_d = `VIU_LOC_PORT;
    end
    if (std_gated[`VIU_IE_T0]) begin
      branch_d = `VIU_LOC_T0;
    end
    if (std_gated[`VIU_IE_AGG]) begin
      branch_d = `VIU_LOC_AGG;
    end
  end

  // Block status: a new source queued, and a retire write with nothing
  // to retire, which usually points at a firmware dispatch bug.
  wire [`VIU_STS_WIDTH-1:0] sts_set = {wr_vec & ~vec_busy, |pushed};
  wire [`VIU_STS_WIDTH-1:0] sts_clr = wr_clr ?
    wdata_q[`VIU_STS_WIDTH-1:0] : {`VIU_STS_WIDTH{1'b0}};

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_ctrl_q <= `VIU_IE_RESET;
      busev_en_q <= `VIU_BE_RESET;
      sts_q <= {`VIU_STS_WIDTH{1'b0}};
      irq_en_q <= {`VIU_STS_WIDTH{1'b0}};
      internal_aggregate_irq_n <= 1'b1;
      core_irq_q <= 6'h00;
      core_branch_addr_q <= `VIU_LOC_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_ie && wstrb_q[0]) begin
        interrupt_enable_ctrl_q <= wdata_q[7:0] & `VIU_IE_WMASK;
      end
      if (wr_be && wstrb_q[0]) begin
        busev_en_q <= wdata_q[7:0] & `VIU_BE_WMASK;
      end
      if (wr_irqen && wstrb_q[0]) begin
        irq_en_q <= wdata_q[`VIU_STS_WIDTH-1:0];
      end
      // Set wins over a clear landing in the same cycle.
      sts_q <= (sts_q & ~sts_clr) | sts_set;
      // Active-low level, so firmware must run the input level-sensitive.
      internal_aggregate_irq_n <= ~agg_pending;
      core_irq_q <= std_gated;
      core_branch_addr_q <= branch_d;
      irq <= |(sts_q & irq_en_q);
    end
  end

  reg [31:0] rdata_d;
  reg rhit_d;
  always @* begin
    rdata_d = 32'h00000000;
    rhit_d = 1'b1;
    case (s_axi_araddr)
      `VIU_ADDR_IE: rdata_d[7:0] = interrupt_enable_ctrl_q;
      `VIU_ADDR_VEC: rdata_d[7:0] = interrupt_vector_id_q;
      `VIU_ADDR_BUSEV_EN: rdata_d[7:0] = busev_en_q;
      `VIU_ADDR_STS: rdata_d[`VIU_STS_WIDTH-1:0] = sts_q;
      `VIU_ADDR_CLR: rdata_d = 32'h00000000;
      `VIU_ADDR_IRQ_EN: rdata_d[`VIU_STS_WIDTH-1:0] = irq_en_q;
      default: rhit_d = 1'b0;
    endcase
  end

  // Write channel: address and data are captured independently, the
  // register write happens once both are held, then the response.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VIU_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[5:2], 2'h0};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `VIU_RESP_OKAY : `VIU_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `VIU_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rhit_d ? `VIU_RESP_OKAY : `VIU_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [sim/viu_top_props.sv]
`timescale 1ns/1ps
`default_nettype none
`include "viu_defines.vh"
module viu_top_props (
  input wire mclk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire setup_received_event,
  input wire internal_aggregate_irq_n,
  input wire [5:0] core_irq_q,
  input wire [15:0] core_branch_addr_q
);
  // Remembers that the read under way targets the vector register.
  logic vec_rd_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vec_rd_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      vec_rd_q <= (s_axi_araddr == `VIU_ADDR_VEC);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_setup_new;
    $rose(setup_received_event) && internal_aggregate_irq_n;
  endsequence
  property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_vec_bit0; vec_rd_q && s_axi_rvalid |-> !s_axi_rdata[0];
  endproperty
  a_vec_bit0: assert property (p_vec_bit0) else $error("vector odd");
  property p_vec_legal; vec_rd_q && s_axi_rvalid |-> s_axi_rdata inside
    {32'h00, 32'h12, 32'h14, 32'h16, 32'h22, 32'h24, 32'h26, 32'h30,
     32'h32, 32'h34, 32'h36, 32'h38, 32'h3A, 32'h3C, 32'h40, 32'h42,
     32'h44, 32'h46}; endproperty
  a_vec_legal: assert property (p_vec_legal) else $error("bad vector");
  property p_agg_branch; core_irq_q[0] |-> core_branch_addr_q == `VIU_LOC_AGG;
  endproperty
  a_agg_branch: assert property (p_agg_branch) else $error("bad branch");
  property p_agg_or; core_irq_q[0] |-> !internal_aggregate_irq_n; endproperty
  a_agg_or: assert property (p_agg_or) else $error("line not low");
  property p_event_line; s_setup_new |-> ##[1:3] !internal_aggregate_irq_n;
  endproperty
  a_event_line: assert property (p_event_line) else $error("no line");
endmodule
bind viu_top viu_top_props viu_top_props_inst (.mclk(mclk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .setup_received_event(setup_received_event),
  .internal_aggregate_irq_n(internal_aggregate_irq_n),
  .core_irq_q(core_irq_q), .core_branch_addr_q(core_branch_addr_q));
`default_nettype wire

// [sim/viu_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module viu_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic internal_aggregate_irq_n,
  output logic [7:0] entries
);
  logic busy_q;
  // Level sensitive: a held low line is one entry, not one per cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      entries <= 8'h00;
    end else begin
      busy_q <= !internal_aggregate_irq_n;
      if (!internal_aggregate_irq_n && !busy_q) entries <= entries + 8'h01;
    end
  end
endmodule
`default_nettype wire

// [sim/vectored_interrupt_unit_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "viu_defines.vh"
module vectored_interrupt_unit_tb_top;
  logic mclk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr, bv, arr, rv, agg_n, irq;
  logic [5:0] aw = 6'h00, ar = 6'h00, cq;
  logic [31:0] wd = 32'h0, rd, d;
  logic [1:0] bre, rre, r;
  logic [4:0] src_lvl = 5'h00;
  logic [16:0] ev = 17'h0;
  logic [15:0] ba;
  logic [7:0] ent;
  int err_total = 0, checks = 0;
  logic [7:0] codes [17] = '{8'h12, 8'h14, 8'h16, 8'h22, 8'h24, 8'h26,
    8'h30, 8'h32, 8'h34, 8'h36, 8'h38, 8'h3A, 8'h3C, 8'h40, 8'h42, 8'h44,
    8'h46};
  logic [15:0] locs [5] = '{16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
  int ord [4] = '{14, 13, 4, 0};
  always #12.5 mclk = ~mclk;
  viu_top viu_top_inst (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(aw),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .timer0_req(src_lvl[0]), .port_irq_req(src_lvl[1]),
    .timer1_req(src_lvl[2]), .serial_port_req(src_lvl[3]),
    .timer2_req(src_lvl[4]),
    .out_ep_event(ev[2:0]), .in_ep_event(ev[5:3]),
    .setup_overwrite_event(ev[6]), .setup_received_event(ev[7]),
    .power_on_event(ev[8]), .power_off_event(ev[9]),
    .resume_event(ev[10]), .suspend_event(ev[11]),
    .bus_reset_event(ev[12]), .serial_bus_transmit_empty(ev[13]),
    .serial_bus_receive_full(ev[14]), .in_ep0_event(ev[15]),
    .out_ep0_event(ev[16]), .internal_aggregate_irq_n(agg_n),
    .core_irq_q(cq), .core_branch_addr_q(ba), .irq(irq));
  viu_core_model viu_core_model_inst (.mclk(mclk), .rst_n(rst_n),
    .internal_aggregate_irq_n(agg_n), .entries(ent));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wrr(input logic [5:0] a, input logic [7:0] v);
    logic ad, wdn;
    ad = 0;
    wdn = 0;
    @(posedge mclk);
    aw <= a;
    wd <= {24'h000000, v};
    awv <= 1;
    wv <= 1;
    br <= 1;
    while (!(ad && wdn)) begin
      @(posedge mclk);
      if (awr && !ad) begin
        ad = 1;
        awv <= 0;
      end
      if (wr && !wdn) begin
        wdn = 1;
        wv <= 0;
      end
    end
    while (!bv) @(posedge mclk);
    br <= 0;
    r = bre;
  endtask
  task rdr(input logic [5:0] a);
    @(posedge mclk);
    ar <= a;
    arv <= 1;
    rr <= 1;
    do @(posedge mclk); while (!arr);
    arv <= 0;
    do @(posedge mclk); while (!rv);
    rr <= 0;
    d = rd;
    r = rre;
  endtask
  task pulse(input int i);
    @(posedge mclk);
    ev <= 17'h1 << i;
    @(posedge mclk);
    ev <= 17'h0;
    repeat (4) @(posedge mclk);
  endtask
  task t_reset;
    rdr(`VIU_ADDR_IE);
    chk(d, 0);
    rdr(`VIU_ADDR_VEC);
    chk(d, 0);
    rdr(`VIU_ADDR_BUSEV_EN);
    chk(d, 0);
  endtask
  task t_std;
    @(posedge mclk);
    src_lvl <= 5'h1F;
    wrr(`VIU_ADDR_IE, 8'h3F);
    repeat (3) @(posedge mclk);
    chk(cq, 0);
    wrr(`VIU_ADDR_IE, 8'hFF);
    rdr(`VIU_ADDR_IE);
    chk(d, 8'hBF);
    // Each step drops the winner, so every lower branch location shows.
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      src_lvl <= 5'h1F << i;
      repeat (3) @(posedge mclk);
      chk(ba, locs[i]);
      chk(cq, {src_lvl, 1'b0});
    end
    src_lvl <= 5'h00;
  endtask
  task t_codes;
    pulse(8);
    rdr(`VIU_ADDR_VEC);
    chk(d, 0);
    wrr(`VIU_ADDR_BUSEV_EN, 8'hF8);
    for (int i = 0; i < 17; i++) begin
      pulse(i);
      rdr(`VIU_ADDR_VEC);
      chk(d, codes[i]);
      wrr(`VIU_ADDR_VEC, 8'h5A);
    end
    repeat (3) @(posedge mclk);
    chk(agg_n, 1);
    chk(ent, 17);
  endtask
  task t_prio;
    pulse(0);
    pulse(4);
    pulse(14);
    pulse(13);
    chk(cq[0], 1);
    chk(ba, 16'h0003);
    for (int k = 0; k < 4; k++) begin
      rdr(`VIU_ADDR_VEC);
      chk(d, codes[ord[k]]);
      wrr(`VIU_ADDR_VEC, 8'h00);
    end
    rdr(`VIU_ADDR_VEC);
    chk(d, 0);
  endtask
  task t_intr;
    wrr(`VIU_ADDR_IRQ_EN, 8'h01);
    pulse(0);
    chk(irq, 1);
    wrr(`VIU_ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge mclk);
    chk(irq, 0);
    wrr(`VIU_ADDR_IRQ_EN, 8'h03);
    wrr(`VIU_ADDR_VEC, 8'h00);
    wrr(`VIU_ADDR_CLR, 8'h01);
    repeat (2) @(posedge mclk);
    chk(irq, 0);
    wrr(`VIU_ADDR_VEC, 8'h00);
    rdr(`VIU_ADDR_STS);
    chk(d, 2);
    chk(irq, 1);
    wrr(`VIU_ADDR_CLR, 8'h03);
    rdr(`VIU_ADDR_STS);
    chk(d, 0);
    rdr(6'h20);
    chk(d, 32'h00000000);
    chk(r, `VIU_RESP_SLVERR);
    wrr(6'h20, 8'h55);
    chk(r, `VIU_RESP_SLVERR);
  endtask
  task finish_test;
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    t_reset;
    t_std;
    t_codes;
    t_prio;
    t_intr;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    finish_test;
  end
endmodule
`default_nettype wire
